// [include/ucc_cfg.svh]
// Register map, field positions, reset values and timing counts of the UART control block.
`ifndef UCC_CFG_SVH
`define UCC_CFG_SVH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define UCC_OFF_CTRL1  8'h00
`define UCC_OFF_CTRL2  8'h04
`define UCC_OFF_STATUS 8'h08
`define UCC_OFF_DATA   8'h0C
`define UCC_OFF_COUNT  8'h10
// ----------------------------------------
// Field positions
// ----------------------------------------
`define UCC_C1_EN    7
`define UCC_C1_WL    6
`define UCC_C1_PEN   5
`define UCC_C1_PT_HI 4
`define UCC_C1_PT_LO 3
`define UCC_C1_BRK   2
`define UCC_C1_TX8   0
`define UCC_C2_TXEN  7
`define UCC_C2_RXEN  6
`define UCC_C2_STOPS 5
`define UCC_C2_ADDEN 4
`define UCC_C2_WAKE  3
`define UCC_C2_RIE   2
`define UCC_C2_TIIE  1
`define UCC_C2_TEIE  0
// ----------------------------------------
// Reset values, timing counts, receive buffer depth and trigger level
// ----------------------------------------
`define UCC_C1_RST     8'h00
`define UCC_C2_RST     8'h00
`define UCC_BREAK_BITS 4'hD
`define UCC_BIT_CYCLES 16
`define UCC_RX_DEPTH   4
`define UCC_RX_TRIG    1
`endif

// [include/ucc_pkg.sv]
// Types shared by the UART control block.
package ucc_pkg;
  typedef enum logic [2:0] {
    TX_IDLE  = 3'b001,
    TX_SHIFT = 3'b010,
    TX_BREAK = 3'b100
  } ucc_tx_state_t;
  typedef enum logic [2:0] {
    RX_IDLE = 3'b001,
    RX_RUN  = 3'b010,
    RX_DONE = 3'b100
  } ucc_rx_state_t;
  typedef enum logic [1:0] {
    PAR_EVEN  = 2'h0,
    PAR_ODD   = 2'h1,
    PAR_MARK  = 2'h2,
    PAR_SPACE = 2'h3
  } ucc_parity_t;
endpackage

// [rtl/ucc_top.sv]
// UART channel control and configuration logic with an APB register slave.
// Summary of operation
// R1: Disabling the unit clears receiver enable, break, receive flags, count; sets idle flags.
// R2: Disabling leaves all other control and configuration bits unchanged.
// R3: Disable aborts transfers; re-enable resumes with the kept configuration.
// R4: Word length 0 selects 8 bits, 1 selects 9 bits with ninth-bit fields.
// R5: With parity on, the last word bit is parity and is not stored.
// R6: Parity is generated and checked only while parity enable is 1.
// R7: Parity type 00 even, 01 odd, 10 mark, 11 space.
// R8: Break waits for buffered data, then holds output low at least 13 bits.
// R9: Transmitter off aborts, resets transmit buffer and floats the output pin.
// R10: Receiver off aborts, resets receive buffer and releases the input pin.
// R11: Receiver checks one or two stop bits; transmitter always sends two.
// R12: With address detect, address bit 1 marks an address and may interrupt.
// R13: With address detect, address bit 0 discards the word without interrupt.
// R14: Clock off and wake enabled, falling input edge raises a wake request.
// R15: No wake request is raised while the UART clock runs.
// R16: Software switches the UART clock back on after a wake interrupt.
// R17: Receive enable passes overrun or receive-available onto the interrupt.
// R18: Transmit-idle enable passes the idle flag onto the interrupt.
// R19: Transmit-empty enable passes the empty flag onto the interrupt.
// R20: Unit off floats both pins; on, pins follow transmitter and receiver enables.
// R21: Receive-available sets when stored words reach the trigger level.
// R22: Transmit idle means empty, nothing shifting, no break, output high.
// R23: Interrupt request is the OR of the three enabled sources; the code also ORs in the wake request.
//
// Local design decisions: the register addresses and the APB slave port.
`timescale 1ns/1ps
`include "ucc_cfg.svh"
module ucc_top #(
  parameter int BIT_CYCLES = `UCC_BIT_CYCLES,
  parameter int RX_DEPTH   = `UCC_RX_DEPTH,
  parameter int RX_TRIG    = `UCC_RX_TRIG
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        serial_in_pin,
  output logic             serial_out_pin,
  output logic             serial_out_oe,
  output logic             serial_in_active,
  input  wire logic        uart_clk_on,
  output logic             wake_request,
  output logic             uart_irq
);
  localparam int TW = $clog2(BIT_CYCLES);
  localparam int PW = $clog2(RX_DEPTH);
  localparam int CW = $clog2(RX_DEPTH + 1);
  // ----------------------------------------
  // Parity
  // ----------------------------------------
  function automatic logic par_bit(input logic [8:0] b, input logic [1:0] t);
    unique case (ucc_pkg::ucc_parity_t'(t))
      ucc_pkg::PAR_EVEN:  par_bit = ^b;
      ucc_pkg::PAR_ODD:   par_bit = ~^b;
      ucc_pkg::PAR_MARK:  par_bit = 1'b1;
      ucc_pkg::PAR_SPACE: par_bit = 1'b0;
    endcase
  endfunction
  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  logic [7:0] c1_reg;
  logic [7:0] c1_next;
  logic [7:0] c2_reg;
  logic [7:0] c2_next;
  wire acc    = psel & penable;
  wire wr     = acc & pwrite;
  wire rd     = acc & ~pwrite;
  wire hit_c1 = paddr == `UCC_OFF_CTRL1;
  wire hit_c2 = paddr == `UCC_OFF_CTRL2;
  wire hit_st = paddr == `UCC_OFF_STATUS;
  wire hit_dt = paddr == `UCC_OFF_DATA;
  wire hit_ct = paddr == `UCC_OFF_COUNT;
  wire mapped = hit_c1 | hit_c2 | hit_st | hit_dt | hit_ct;
  assign pready  = 1'b1;
  assign pslverr = acc & ~mapped;
  wire en      = c1_reg[`UCC_C1_EN];
  wire wl      = c1_reg[`UCC_C1_WL];
  wire pen     = c1_reg[`UCC_C1_PEN];
  wire [1:0] pt = c1_reg[`UCC_C1_PT_HI:`UCC_C1_PT_LO];
  wire brk     = c1_reg[`UCC_C1_BRK];
  wire tx_on   = en & c2_reg[`UCC_C2_TXEN];
  wire rx_on   = en & c2_reg[`UCC_C2_RXEN];
  wire stops   = c2_reg[`UCC_C2_STOPS];
  wire adden   = c2_reg[`UCC_C2_ADDEN];
  // Only the receiver enable and break bits follow the unit enable; the rest is kept. R2
  always_comb begin
    c1_next = (wr & hit_c1) ? pwdata[7:0] : c1_reg;
    c2_next = (wr & hit_c2) ? pwdata[7:0] : c2_reg;
    if (!c1_next[`UCC_C1_EN]) begin
      c1_next[`UCC_C1_BRK]  = 1'b0; // R1
      c2_next[`UCC_C2_RXEN] = 1'b0; // R1
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      c1_reg <= `UCC_C1_RST;
      c2_reg <= `UCC_C2_RST;
    end else begin
      c1_reg <= c1_next;
      c2_reg <= c2_next;
    end
  end

  // ----------------------------------------
  // Transmitter
  // ----------------------------------------
  ucc_pkg::ucc_tx_state_t tx_st_reg;
  logic [8:0]    hold_reg;
  logic          full_reg;
  logic [11:0]   tsh_reg;
  logic [3:0]    tbit_reg;
  logic [TW-1:0] ttick_reg;
  wire tx_load = wr & hit_dt & tx_on;
  wire tx_p    = par_bit(wl ? {1'b0, hold_reg[7:0]} : {2'b00, hold_reg[6:0]}, pt); // R7
  wire [8:0] tx_w = !pen ? hold_reg : // R6
                    wl ? {tx_p, hold_reg[7:0]} : {1'b0, tx_p, hold_reg[6:0]}; // R5
  // Two stop bits are always framed in. R11
  wire [11:0] tx_frame = wl ? {2'b11, tx_w, 1'b0} : {3'b111, tx_w[7:0], 1'b0}; // R4
  wire tick0 = ttick_reg == '0;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      full_reg <= 1'b0;
      hold_reg <= '0;
    end else if (!tx_on) begin
      full_reg <= 1'b0; // R9
    end else if (tx_load) begin
      full_reg <= 1'b1;
      hold_reg <= {c1_reg[`UCC_C1_TX8], pwdata[7:0]}; // R4
    end else if (tx_st_reg == ucc_pkg::TX_IDLE) begin
      full_reg <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_st_reg <= ucc_pkg::TX_IDLE;
      tsh_reg   <= 12'hFFF;
      tbit_reg  <= '0;
      ttick_reg <= '0;
    end else if (!tx_on) begin
      tx_st_reg <= ucc_pkg::TX_IDLE; // R3
      tsh_reg   <= 12'hFFF;
    end else begin
      ttick_reg <= tick0 ? TW'(BIT_CYCLES - 1) : ttick_reg - 1'b1;
      unique case (tx_st_reg)
        ucc_pkg::TX_IDLE: begin
          ttick_reg <= TW'(BIT_CYCLES - 1);
          tbit_reg  <= '0;
          if (full_reg) begin
            tx_st_reg <= ucc_pkg::TX_SHIFT;
            tsh_reg   <= tx_frame;
            tbit_reg  <= wl ? 4'hB : 4'hA;
          end else if (brk) begin
            tx_st_reg <= ucc_pkg::TX_BREAK; // R8
            tsh_reg   <= 12'h000;
          end
        end
        ucc_pkg::TX_SHIFT: begin
          if (tick0) begin
            tsh_reg  <= {1'b1, tsh_reg[11:1]};
            tbit_reg <= tbit_reg - 1'b1;
            if (tbit_reg == '0) begin
              tx_st_reg <= ucc_pkg::TX_IDLE;
            end
          end
        end
        ucc_pkg::TX_BREAK: begin
          if (tick0 && tbit_reg != `UCC_BREAK_BITS) begin
            tbit_reg <= tbit_reg + 1'b1;
          end
          if (!brk && tbit_reg == `UCC_BREAK_BITS) begin
            tx_st_reg <= ucc_pkg::TX_IDLE; // R8
            tsh_reg   <= 12'hFFF;
          end
        end
      endcase
    end
  end
  assign serial_out_pin = tsh_reg[0];
  assign serial_out_oe  = tx_on; // R9 R20
  wire tx_empty = ~full_reg;
  wire tx_idle  = tx_empty & (tx_st_reg == ucc_pkg::TX_IDLE) & ~brk; // R22
  // ----------------------------------------
  // Receiver
  // ----------------------------------------
  ucc_pkg::ucc_rx_state_t rx_st_reg;
  logic [11:0]   rsh_reg;
  logic [3:0]    ridx_reg;
  logic [TW-1:0] rtick_reg;
  logic          rprev_reg;
  logic          noisy_reg;
  wire [3:0] rlast = 4'h9 + {3'b000, wl} + {3'b000, stops}; // R11
  wire rtick0 = rtick_reg == '0;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_st_reg <= ucc_pkg::RX_IDLE;
      rsh_reg   <= '0;
      ridx_reg  <= '0;
      rtick_reg <= '0;
      noisy_reg <= 1'b0;
    end else if (!rx_on) begin
      rx_st_reg <= ucc_pkg::RX_IDLE; // R10
    end else begin
      unique case (rx_st_reg)
        ucc_pkg::RX_IDLE: begin
          ridx_reg  <= '0;
          noisy_reg <= 1'b0;
          rtick_reg <= TW'(BIT_CYCLES / 2);
          if (rprev_reg && !serial_in_pin) begin
            rx_st_reg <= ucc_pkg::RX_RUN;
          end
        end
        ucc_pkg::RX_RUN: begin
          rtick_reg <= rtick0 ? TW'(BIT_CYCLES - 1) : rtick_reg - 1'b1;
          if (rtick0) begin
            rsh_reg[ridx_reg] <= serial_in_pin;
            ridx_reg <= ridx_reg + 1'b1;
            if (serial_in_pin != rprev_reg) begin
              noisy_reg <= 1'b1;
            end
            if (ridx_reg == '0 && serial_in_pin) begin
              rx_st_reg <= ucc_pkg::RX_IDLE;
            end else if (ridx_reg == rlast) begin
              rx_st_reg <= ucc_pkg::RX_DONE;
            end
          end
        end
        ucc_pkg::RX_DONE: begin
          rx_st_reg <= ucc_pkg::RX_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rprev_reg <= 1'b1;
    end else begin
      rprev_reg <= serial_in_pin;
    end
  end
  assign serial_in_active = rx_on; // R10 R20
  wire [8:0] rw = wl ? rsh_reg[9:1] : {1'b0, rsh_reg[8:1]}; // R4
  wire r_stop1  = wl ? rsh_reg[10] : rsh_reg[9];
  wire r_stop2  = wl ? rsh_reg[11] : rsh_reg[10];
  wire r_ferr   = ~r_stop1 | (stops & ~r_stop2); // R11
  wire r_exp    = par_bit(wl ? {1'b0, rw[7:0]} : {2'b00, rw[6:0]}, pt); // R7
  wire r_perr   = pen & (r_exp != (wl ? rw[8] : rw[7])); // R6
  wire r_addr   = wl ? rw[8] : rw[7]; // R12
  wire r_keep   = ~adden | r_addr; // R13
  wire [8:0] r_store = {wl & ~pen & rw[8], (pen & ~wl) ? 1'b0 : rw[7], rw[6:0]}; // R5
  wire r_done   = rx_st_reg == ucc_pkg::RX_DONE;
  wire rx_idle  = rx_st_reg != ucc_pkg::RX_RUN;
  // ----------------------------------------
  // Receive buffer
  // ----------------------------------------
  // The pointers wrap by overflow, so the depth must be a power of two.
  logic [8:0]    fifo_mem [RX_DEPTH];
  logic [PW-1:0] wp_reg;
  logic [PW-1:0] rp_reg;
  logic [CW-1:0] cnt_reg;
  wire full_f = cnt_reg == CW'(RX_DEPTH);
  wire push   = r_done & r_keep & ~full_f; // R13
  wire ovr_ev = r_done & r_keep & full_f;
  wire pop    = rd & hit_dt & (cnt_reg != '0);
  wire rx_avail = cnt_reg >= CW'(RX_TRIG); // R21
  always_ff @(posedge pclk) begin
    if (push) begin
      fifo_mem[wp_reg] <= r_store;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wp_reg  <= '0;
      rp_reg  <= '0;
      cnt_reg <= '0;
    end else if (!rx_on) begin
      wp_reg  <= '0; // R1 R10
      rp_reg  <= '0;
      cnt_reg <= '0;
    end else begin
      wp_reg  <= wp_reg + PW'(push);
      rp_reg  <= rp_reg + PW'(pop);
      cnt_reg <= cnt_reg + CW'(push) - CW'(pop);
    end
  end

  // ----------------------------------------
  // Error flags
  // ----------------------------------------
  // A status read arms the clear; the next data access clears. New errors win.
  logic armed_reg;
  logic ovr_reg;
  logic ferr_reg;
  logic perr_reg;
  logic nf_reg;
  wire clr_err = armed_reg & acc & hit_dt;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      armed_reg <= 1'b0;
      ovr_reg   <= 1'b0;
      ferr_reg  <= 1'b0;
      perr_reg  <= 1'b0;
      nf_reg    <= 1'b0;
    end else if (!en) begin
      armed_reg <= 1'b0; // R1
      ovr_reg   <= 1'b0;
      ferr_reg  <= 1'b0;
      perr_reg  <= 1'b0;
      nf_reg    <= 1'b0;
    end else begin
      armed_reg <= (rd & hit_st) | (armed_reg & ~(acc & hit_dt));
      ovr_reg   <= ovr_ev | (ovr_reg & ~clr_err);
      ferr_reg  <= (push & r_ferr) | (ferr_reg & ~clr_err);
      perr_reg  <= (push & r_perr) | (perr_reg & ~clr_err);
      nf_reg    <= (push & noisy_reg) | (nf_reg & ~clr_err);
    end
  end

  // ----------------------------------------
  // Wake-up and interrupt request
  // ----------------------------------------
  logic wake_reg;
  wire fall = rprev_reg & ~serial_in_pin;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_reg <= 1'b0;
    end else if (uart_clk_on) begin
      wake_reg <= 1'b0; // R15 R16
    end else if (c2_reg[`UCC_C2_WAKE] && fall) begin
      wake_reg <= 1'b1; // R14
    end
  end

  assign wake_request = wake_reg;
  wire irq_rx = c2_reg[`UCC_C2_RIE]  & (ovr_reg | rx_avail); // R12 R17
  wire irq_ti = c2_reg[`UCC_C2_TIIE] & tx_idle; // R18
  wire irq_te = c2_reg[`UCC_C2_TEIE] & tx_empty; // R19
  assign uart_irq = irq_rx | irq_ti | irq_te | wake_reg; // R14 R23
  // ----------------------------------------
  // Read data
  // ----------------------------------------
  wire [8:0] head = (cnt_reg != '0) ? fifo_mem[rp_reg] : 9'h000;
  wire [7:0] rd_c1 = {c1_reg[7:2], head[8], 1'b0};
  wire [7:0] rd_st = {perr_reg, nf_reg, ferr_reg, ovr_reg, rx_idle, rx_avail, tx_idle, tx_empty};
  wire [7:0] rd_mux = hit_c1 ? rd_c1 :
                      hit_c2 ? c2_reg :
                      hit_st ? rd_st :
                      hit_dt ? head[7:0] :
                      hit_ct ? 8'(cnt_reg) : 8'h00;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable) begin
      prdata <= {24'h000000, rd_mux};
    end
  end
endmodule

// [verification/ucc_peer.sv]
// Behavioural serial peer: sends frames to the receiver and captures transmitted frames.
`timescale 1ns/1ps
module ucc_peer #(
  parameter int BIT_CYCLES = 16
) (
  input  wire logic serial_out_pin,
  input  wire logic serial_out_oe,
  output logic      serial_in_pin
);
  localparam int TB_NS = BIT_CYCLES * 8;
  // The transmit line has a pull-up, so a floating output reads high, not its last level.
  wire logic line = serial_out_oe ? serial_out_pin : 1'b1;
  initial serial_in_pin = 1'b1;
  // Bits go out LSB first; the caller packs one or two stop bits.
  task automatic send(input logic [11:0] bits);
    #1;
    for (int i = 0; i < 12; i++) begin
      serial_in_pin = bits[i];
      #(TB_NS);
    end
    serial_in_pin = 1'b1;
  endtask
  task automatic capture(output logic [11:0] bits);
    bits = '1;
    @(negedge line);
    #(TB_NS / 2);
    for (int i = 0; i < 12; i++) begin
      bits[i] = line;
      #(TB_NS);
    end
  endtask
endmodule

// [verification/ucc_top_sva.sv]
// Port-level checker of the UART control block.
`timescale 1ns/1ps
`include "ucc_cfg.svh"
module ucc_top_sva #(
  parameter int BIT_CYCLES = 16
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        serial_in_pin,
  input wire logic        serial_out_pin,
  input wire logic        serial_out_oe,
  input wire logic        serial_in_active,
  input wire logic        uart_clk_on,
  input wire logic        wake_request,
  input wire logic        uart_irq
);
  logic [7:0]  c1_reg;
  logic [7:0]  c2_reg;
  logic [15:0] low_reg;
  wire logic   acc   = psel & penable & pwrite;
  wire logic   wr_c1 = acc & (paddr == `UCC_OFF_CTRL1);
  wire logic   wr_c2 = acc & (paddr == `UCC_OFF_CTRL2);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // A shadow of both control registers lets the pin enables be judged from bus traffic alone.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      c1_reg <= 8'h00;
      c2_reg <= 8'h00;
    end else begin
      if (wr_c1) c1_reg <= pwdata[7:0];
      if (wr_c2) c2_reg <= {pwdata[7], pwdata[6] & c1_reg[7], pwdata[5:0]};
      else if (wr_c1 && !pwdata[7]) c2_reg[6] <= 1'b0;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) low_reg <= 16'h0000;
    else if (!serial_out_oe || serial_out_pin) low_reg <= 16'h0000;
    else if (low_reg != 16'hFFFF) low_reg <= low_reg + 16'h0001;
  end
  property p_tx_oe;
    serial_out_oe == (c1_reg[7] & c2_reg[7]);
  endproperty
  a_tx_oe: assert property (p_tx_oe) else $error("transmit pin enable wrong");
  property p_rx_active;
    serial_in_active == (c1_reg[7] & c2_reg[6]);
  endproperty
  a_rx_active: assert property (p_rx_active) else $error("receive pin ownership wrong");
  property p_disable_rx;
    wr_c1 && !pwdata[7] |=> !serial_in_active [*2];
  endproperty
  a_disable_rx: assert property (p_disable_rx) else $error("receiver kept after disable");
  property p_wake_clk;
    uart_clk_on |=> !wake_request;
  endproperty
  a_wake_clk: assert property (p_wake_clk) else $error("wake request with clock running");
  property p_wake_off;
    !c2_reg[3] && !wake_request |=> !wake_request;
  endproperty
  a_wake_off: assert property (p_wake_off) else $error("wake request while wake disabled");
  property p_wake_rise;
    c1_reg[7] && c2_reg[3] && !uart_clk_on && $fell(serial_in_pin) |-> ##[0:4] wake_request;
  endproperty
  a_wake_rise: assert property (p_wake_rise) else $error("falling edge raised no wake request");
  property p_wake_irq;
    wake_request |-> uart_irq;
  endproperty
  a_wake_irq: assert property (p_wake_irq) else $error("wake request not on interrupt");
  property p_irq_masked;
    c2_reg[2:0] == 3'h0 && !wake_request |-> !uart_irq;
  endproperty
  a_irq_masked: assert property (p_irq_masked) else $error("interrupt with all sources masked");
  property p_break_len;
    serial_out_oe && $rose(serial_out_pin) && low_reg > 11 * BIT_CYCLES |-> low_reg >= 13 * BIT_CYCLES;
  endproperty
  a_break_len: assert property (p_break_len) else $error("break shorter than thirteen bits");
endmodule
bind ucc_top ucc_top_sva #(.BIT_CYCLES(BIT_CYCLES)) chk_u (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .serial_in_pin(serial_in_pin),
  .serial_out_pin(serial_out_pin), .serial_out_oe(serial_out_oe), .serial_in_active(serial_in_active),
  .uart_clk_on(uart_clk_on), .wake_request(wake_request), .uart_irq(uart_irq)
);

// [verification/test_uart_control_config.sv]
// Self-checking testbench of the UART control block.
`timescale 1ns/1ps
`include "ucc_cfg.svh"
module test_uart_control_config;
  localparam int B = 4;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic        uart_clk_on = 1'b1;
  logic [31:0] prdata;
  logic        pready, pslverr, serial_in_pin, serial_out_pin, serial_out_oe, serial_in_active;
  logic        wake_request, uart_irq, last_err;
  int          miscompares = 0;
  int          comparisons = 0;
  always #4 pclk = ~pclk;
  ucc_top #(.BIT_CYCLES(B)) dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .serial_in_pin(serial_in_pin),
    .serial_out_pin(serial_out_pin), .serial_out_oe(serial_out_oe), .serial_in_active(serial_in_active),
    .uart_clk_on(uart_clk_on), .wake_request(wake_request), .uart_irq(uart_irq));
  ucc_peer #(.BIT_CYCLES(B)) peer_u (
    .serial_out_pin(serial_out_pin), .serial_out_oe(serial_out_oe), .serial_in_pin(serial_in_pin));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    if (miscompares == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // The request is held until pready is seen high; no fixed answer latency is assumed.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    r = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(1'b1, a, d, r);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    apb(1'b0, a, 32'h0, r);
    chk(r, e);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    logic [31:0] r;
    rd(`UCC_OFF_CTRL1, 32'h00);
    rd(`UCC_OFF_CTRL2, 32'h00);
    rd(`UCC_OFF_STATUS, 32'h0B);
    apb(1'b0, 8'h14, 32'h0, r);
    chk(r, 32'h0);
    chk(last_err, 1'b1);
  endtask
  task automatic t_tx();
    logic [11:0] f;
    logic [7:0]  d = 8'h35;
    logic        p;
    wr(`UCC_OFF_CTRL2, 32'h80);
    for (int t = 0; t < 4; t++) begin
      wr(`UCC_OFF_CTRL1, 32'hA0 | (32'(t) << 3));
      p = (t == 0) ? ^d[6:0] : (t == 1) ? ~^d[6:0] : (t == 2);
      fork
        peer_u.capture(f);
        wr(`UCC_OFF_DATA, {24'h0, d});
      join
      chk(f, {1'b1, 2'b11, p, d[6:0], 1'b0});
      cyc(2 * B);
    end
    wr(`UCC_OFF_CTRL1, 32'hC1);
    fork
      peer_u.capture(f);
      wr(`UCC_OFF_DATA, 32'h5A);
    join
    chk(f, {2'b11, 1'b1, 8'h5A, 1'b0});
    cyc(2 * B);
    wr(`UCC_OFF_CTRL2, 32'h81);
    @(negedge pclk);
    chk(uart_irq, 1'b1);
    wr(`UCC_OFF_CTRL2, 32'h82);
    @(negedge pclk);
    chk(uart_irq, 1'b1);
  endtask
  task automatic t_break();
    int n = 0;
    wr(`UCC_OFF_CTRL2, 32'h80);
    wr(`UCC_OFF_CTRL1, 32'h84);
    for (int k = 0; k < 4 * B && peer_u.line !== 1'b0; k++) @(negedge pclk);
    fork
      while (peer_u.line === 1'b0 && n < 40 * B) begin
        @(negedge pclk);
        n++;
      end
      begin
        cyc(2 * B);
        wr(`UCC_OFF_CTRL1, 32'h80);
      end
    join
    chk(n >= 13 * B, 1'b1);
    chk(peer_u.line, 1'b1);
  endtask
  task automatic t_rx();
    wr(`UCC_OFF_CTRL2, 32'h44);
    peer_u.send({3'b111, 8'hA5, 1'b0});
    cyc(4);
    @(negedge pclk);
    chk(uart_irq, 1'b1);
    rd(`UCC_OFF_COUNT, 32'h1);
    rd(`UCC_OFF_DATA, 32'hA5);
    wr(`UCC_OFF_CTRL1, 32'hA0);
    wr(`UCC_OFF_CTRL2, 32'h64);
    peer_u.send({3'b111, 1'b1, 7'h43, 1'b0});
    cyc(4);
    rd(`UCC_OFF_DATA, 32'h43);
    peer_u.send({3'b111, 1'b0, 7'h43, 1'b0});
    cyc(4);
    rd(`UCC_OFF_STATUS, 32'h8F);
    rd(`UCC_OFF_DATA, 32'h43);
    rd(`UCC_OFF_STATUS, 32'h0B);
    wr(`UCC_OFF_CTRL1, 32'h80);
    wr(`UCC_OFF_CTRL2, 32'h54);
    peer_u.send({3'b111, 8'h12, 1'b0});
    cyc(4);
    rd(`UCC_OFF_COUNT, 32'h0);
    peer_u.send({3'b111, 8'h92, 1'b0});
    cyc(4);
    @(negedge pclk);
    chk(uart_irq, 1'b1);
    rd(`UCC_OFF_DATA, 32'h92);
    wr(`UCC_OFF_CTRL1, 32'hC0);
    wr(`UCC_OFF_CTRL2, 32'h44);
    peer_u.send({2'b11, 1'b1, 8'h3C, 1'b0});
    cyc(4);
    rd(`UCC_OFF_CTRL1, 32'hC2);
  endtask
  // The ninth-bit word is left unread so that disabling has a stored word to discard.
  task automatic t_disable();
    wr(`UCC_OFF_CTRL2, 32'hE6);
    wr(`UCC_OFF_CTRL1, 32'h40);
    rd(`UCC_OFF_CTRL1, 32'h40);
    rd(`UCC_OFF_CTRL2, 32'hA6);
    rd(`UCC_OFF_STATUS, 32'h0B);
    rd(`UCC_OFF_COUNT, 32'h0);
    wr(`UCC_OFF_CTRL1, 32'hC0);
    rd(`UCC_OFF_CTRL2, 32'hA6);
    @(negedge pclk);
    chk(serial_out_oe, 1'b1);
  endtask
  task automatic t_wake(input logic [31:0] c2, input logic exp);
    wr(`UCC_OFF_CTRL2, c2);
    @(posedge pclk);
    uart_clk_on <= 1'b0;
    peer_u.send(12'hFFE);
    cyc(4);
    @(negedge pclk);
    chk(wake_request, exp);
    chk(uart_irq, exp);
    @(posedge pclk);
    uart_clk_on <= 1'b1;
    cyc(2);
    @(negedge pclk);
    chk(wake_request, 1'b0);
  endtask
  initial begin
    cyc(16);
    presetn <= 1'b1;
    t_reset();
    t_tx();
    t_break();
    t_rx();
    t_disable();
    t_wake(32'h08, 1'b1);
    t_wake(32'h00, 1'b0);
    finish_test();
  end
  initial begin
    #200000;
    miscompares++;
    finish_test();
  end
endmodule
